// ### tb/cie_core_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module cie_core_asserts #(
    parameter PC_W = 13
) (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic [PC_W-1:0] o_pm_addr,
    input wire logic [13:0] i_pm_data,
    input wire logic o_sleep,
    input wire logic i_hsel,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic o_hreadyout,
    input wire logic [31:0] o_hrdata,
    input wire logic o_hresp
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    wire logic taken = i_hsel && i_htrans[1] && i_hready;
    wire logic ret_op = i_pm_data == 14'h0008 || i_pm_data == 14'h0009
        || i_pm_data[13:10] == 4'hd;
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    a_resp_okay: assert property (o_hresp == 1'b0)
        else $error("bus response not okay");
    a_write_no_wait: assert property (taken && i_hwrite |=> o_hreadyout)
        else $error("write inserted a wait state");
    a_read_one_wait: assert property (taken && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
        else $error("read answer timing wrong");
    a_rdata_stands: assert property (o_hreadyout && $past(o_hreadyout) |-> $stable(o_hrdata))
        else $error("read data moved without a read");
    a_insn_single: assert property ($changed(o_pm_addr) |=> $stable(o_pm_addr) [*3])
        else $error("instruction shorter than one cycle");
    a_return_dead: assert property ($changed(o_pm_addr) && $past(ret_op)
        |=> $stable(o_pm_addr) [*7]) else $error("return did not take two cycles");
    a_sleep_entry: assert property ($changed(o_pm_addr) && $past(i_pm_data) == 14'h0063
        |-> o_sleep) else $error("sleep not entered");
    a_sleep_halts: assert property (o_sleep && $past(o_sleep) |-> $stable(o_pm_addr))
        else $error("program counter moved while asleep");
    c_sleep: cover property ($rose(o_sleep));
    c_read: cover property (taken && !i_hwrite);
    c_return: cover property ($changed(o_pm_addr) && $past(ret_op));
endmodule // cie_core_asserts

bind cie_core cie_core_asserts #(.PC_W(PC_W)) u_cie_core_asserts (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .o_pm_addr(o_pm_addr),
    .i_pm_data(i_pm_data),
    .o_sleep(o_sleep),
    .i_hsel(i_hsel),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hready(i_hready),
    .o_hreadyout(o_hreadyout),
    .o_hrdata(o_hrdata),
    .o_hresp(o_hresp)
);
`default_nettype wire

// ### tb/cie_pmem_model.sv
`timescale 1ns/100ps
`default_nettype none
module cie_pmem_model #(
    parameter PC_W = 13
) (
    input wire logic [PC_W-1:0] i_addr,
    output logic [13:0] o_data
);
    // Idle words everywhere, so a run that overshoots its program is harmless
    logic [13:0] mem [0:(1<<PC_W)-1];
    initial begin
        for (int i = 0; i < (1 << PC_W); i++) begin
            mem[i] = 14'h0000;
        end
    end
    // Combinational: three clocks of margin before each executing edge
    assign o_data = mem[i_addr];
endmodule // cie_pmem_model
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "cie_defs.vh"
module testbench;
    logic clk = 1'b0, srst = 1'b1, wake = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, c;
    wire logic [12:0] pm_addr;
    wire logic [13:0] pm_data;
    wire logic sleep, hready, hresp;
    wire logic [31:0] hrdata;
    int miscompares = 0, n_tests = 0, cyc = 0;
    cie_core u_cie_core (.i_sys_clk(clk), .i_srst(srst), .o_pm_addr(pm_addr),
        .i_pm_data(pm_data), .i_wake(wake), .o_sleep(sleep), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
        .o_hrdata(hrdata), .o_hresp(hresp));
    cie_pmem_model u_cie_pmem_model (.i_addr(pm_addr), .o_data(pm_data));
    initial begin
        forever #20 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // Bus master and helpers
    // ----------------------------------------------------------------
    // Ready is sampled at the rising edge; the slave only moves it after that edge
    task wrdy;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
    endtask
    task wr(input [31:0] a, input [31:0] d);
        hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= 1'b1;
        wrdy;
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        wrdy;
    endtask
    task rd(input [31:0] a, output [31:0] d);
        hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= 1'b0;
        wrdy;
        hsel <= 1'b0; htrans <= 2'h0;
        wrdy;
        d = hrdata;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task rchk(input [31:0] a, input [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp);
    endtask
    function automatic [31:0] fa(input [6:0] f);
        fa = 32'h200 + {23'h0, f, 2'h0};
    endfunction
    task pm(input [12:0] a, input [13:0] v);
        u_cie_pmem_model.mem[a] <= v;
    endtask
    task go(input [12:0] pc, input [7:0] w, input [7:0] st);
        wr(`CIE_OFS_PC, {19'h0, pc});
        wr(`CIE_OFS_WREG, {24'h0, w});
        wr(`CIE_OFS_STATUS, {24'h0, st});
        wr(`CIE_OFS_CTRL, 32'h1);
    endtask
    // Control is read back while running; stopping clears the enable bits
    task run(input [12:0] pc, input [7:0] w, input [7:0] st, input int n);
        go(pc, w, st);
        repeat (n) @(posedge clk);
        rd(`CIE_OFS_CTRL, c);
        wr(`CIE_OFS_CTRL, 32'h0);
        repeat (4) @(posedge clk);
    endtask
    task print_verdict;
        if (miscompares == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_reset;
        rchk(`CIE_OFS_STATUS, 32'h18);
        wr(32'h100, 32'hffff);
        rchk(32'h100, 32'h0);
    endtask
    task t_moves;
        wr(fa(7'h21), 32'ha5); wr(fa(7'h20), 32'h0); wr(fa(7'h7f), 32'h0);
        pm(13'h10, 14'h0821); pm(13'h11, 14'h00ff); pm(13'h12, 14'h08a0);
        pm(13'h13, 14'h30ff);
        run(13'h10, 8'h00, 8'h19, 40);
        rchk(`CIE_OFS_WREG, 32'hff);
        rchk(fa(7'h7f), 32'ha5);
        rchk(fa(7'h21), 32'ha5);
        rchk(fa(7'h20), 32'h00);
        rchk(`CIE_OFS_STATUS, 32'h1d);
    endtask
    task t_rot;
        wr(fa(7'h30), 32'h81); wr(fa(7'h31), 32'h02); wr(fa(7'h32), 32'h40);
        pm(13'h20, 14'h0db0); pm(13'h21, 14'h0c31); pm(13'h22, 14'h0db2);
        run(13'h20, 8'h00, 8'h19, 40);
        rchk(fa(7'h30), 32'h03);
        rchk(fa(7'h31), 32'h02);
        rchk(`CIE_OFS_WREG, 32'h81);
        rchk(fa(7'h32), 32'h80);
        rchk(`CIE_OFS_STATUS, 32'h18);
    endtask
    task sub1(input [7:0] k, input [7:0] w, input [7:0] r, input [7:0] st);
        pm(13'h30, {6'h3c, k});
        run(13'h30, w, 8'h18, 12);
        rchk(`CIE_OFS_WREG, {24'h0, r});
        rchk(`CIE_OFS_STATUS, {24'h0, st});
    endtask
    task t_sub;
        sub1(8'h10, 8'h01, 8'h0f, 8'h19);
        sub1(8'h05, 8'h05, 8'h00, 8'h1f);
        sub1(8'h00, 8'h01, 8'hff, 8'h18);
    endtask
    task t_ret;
        wr(`CIE_OFS_STACK, 32'h50); wr(`CIE_OFS_STACK, 32'h60); wr(`CIE_OFS_STACK, 32'h70);
        pm(13'h40, 14'h0009); pm(13'h41, 14'h30ee); pm(13'h70, 14'h0008);
        pm(13'h71, 14'h30ee); pm(13'h60, 14'h3477); pm(13'h61, 14'h30ee);
        run(13'h40, 8'h00, 8'h1f, 60);
        chk(c, 32'h3);
        rchk(`CIE_OFS_WREG, 32'h77);
        rchk(`CIE_OFS_STATUS, 32'h1f);
    endtask
    task t_sleep;
        int i;
        pm(13'h83, 14'h0063); pm(13'h84, 14'h303c);
        go(13'h80, 8'h00, 8'h08);
        for (i = 0; i < 100 && sleep !== 1'b1; i++) @(posedge clk);
        chk({31'h0, sleep}, 32'h1);
        rchk(`CIE_OFS_STATUS, 32'h30);
        // Prescaler keeps counting in sleep, so a few ticks are allowed
        rd(`CIE_OFS_WATCHDOG, c);
        chk({24'h0, c[7:0]}, 32'h0);
        chk({31'h0, c[15:8] < 8'h04}, 32'h1);
        repeat (20) @(posedge clk);
        rchk(`CIE_OFS_WREG, 32'h0);
        wake <= 1'b1;
        for (i = 0; i < 100 && sleep !== 1'b0; i++) @(posedge clk);
        wake <= 1'b0;
        repeat (20) @(posedge clk);
        rchk(`CIE_OFS_WREG, 32'h3c);
        wr(`CIE_OFS_CTRL, 32'h0);
    endtask
    // ----------------------------------------------------------------
    // Sequence and watchdog on the run
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            print_verdict;
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_moves;
        t_rot;
        t_sub;
        t_ret;
        t_sleep;
        print_verdict;
    end
endmodule // testbench
`default_nettype wire

// ### verilog/cie_alu.v
`timescale 1ns/100ps
`default_nettype none
`include "cie_defs.vh"

module cie_alu (
    input wire [1:0] i_op,
    input wire [7:0] i_opnd,
    input wire [7:0] i_wreg,
    input wire i_carry,
    output reg [7:0] o_res,
    output reg o_c,
    output reg o_digit_carry,
    output wire o_z
);
    always @* begin
        o_res = i_opnd;
        o_c = i_carry;
        o_digit_carry = 1'b0;
        case (i_op)
            `CIE_ALU_RLC: begin
                o_res = {i_opnd[6:0], i_carry}; // [RL6]
                o_c = i_opnd[7]; // [RL6]
            end
            `CIE_ALU_RRC: begin
                o_res = {i_carry, i_opnd[7:1]}; // [RL7]
                o_c = i_opnd[0]; // [RL7]
            end
            `CIE_ALU_SUB: begin
                // Carry is the inverse of borrow
                o_res = i_opnd - i_wreg; // [RL12]
                o_c = (i_opnd >= i_wreg); // [RL12]
                o_digit_carry = (i_opnd[3:0] >= i_wreg[3:0]); // [RL12]
            end
            default: begin
                o_res = i_opnd;
            end
        endcase
    end

    assign o_z = (o_res == 8'h00);
endmodule // cie_alu

`default_nettype wire

// ### verilog/cie_core.v
`timescale 1ns/100ps
`default_nettype none
`include "cie_defs.vh"

module cie_core #(
    parameter CLK_PER_INSN = `CIE_CLK_PER_INSN,
    parameter STACK_DEPTH = 8,
    parameter STACK_AW = 3,
    parameter PC_W = 13
) (
    input wire i_sys_clk,
    input wire i_srst,
    // Program memory
    output reg [PC_W-1:0] o_pm_addr,
    input wire [13:0] i_pm_data,
    // Wake-up pin
    input wire i_wake,
    output reg o_sleep,
    // AHB-Lite slave
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire [2:0] i_hsize,
    input wire [31:0] i_hwdata,
    input wire i_hready,
    output reg o_hreadyout,
    output reg [31:0] o_hrdata,
    output reg o_hresp
);
    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    function [3:0] insn_class;
        input [13:0] insn;
        begin
            insn_class = `CIE_CL_IDLE;
            if (insn[13:8] == 6'b001000)
                insn_class = `CIE_CL_MOVE_FILE;
            else if (insn[13:7] == 7'b0000001)
                insn_class = `CIE_CL_STORE_WORKING;
            else if (insn[13:10] == 4'b1100)
                insn_class = `CIE_CL_LOAD_LITERAL;
            else if (insn[13:10] == 4'b1101)
                insn_class = `CIE_CL_RETURN_LITERAL;
            else if (insn == 14'h0009)
                insn_class = `CIE_CL_IRQ_RETURN;
            else if (insn == 14'h0008)
                insn_class = `CIE_CL_RETURN;
            else if (insn[13:8] == 6'b001101)
                insn_class = `CIE_CL_ROTATE_LEFT;
            else if (insn[13:8] == 6'b001100)
                insn_class = `CIE_CL_ROTATE_RIGHT;
            else if (insn == 14'h0063)
                insn_class = `CIE_CL_SLEEP;
            else if (insn[13:9] == 5'b11110)
                insn_class = `CIE_CL_LITERAL_SUB;
        end
    endfunction

    function is_return;
        input [3:0] cl;
        begin
            is_return = (cl == `CIE_CL_RETURN_LITERAL) || (cl == `CIE_CL_IRQ_RETURN) ||
                (cl == `CIE_CL_RETURN);
        end
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg [7:0] file_mem [0:127];
    reg [PC_W-1:0] stack_mem [0:STACK_DEPTH-1];
    reg [STACK_AW-1:0] sp_r;
    reg [PC_W-1:0] pc_r;
    reg [7:0] wreg_r;
    reg [4:0] status_r;
    reg [7:0] ctrl_r;
    reg sleep_r;
    reg flush_r;
    reg [7:0] wdog_cnt_r;
    reg [7:0] wdog_pre_r;
    reg [7:0] div_r;
    reg cyc_en_r;
    reg [2:0] wake_sync_r;
    reg [11:0] bus_addr_r;
    reg bus_wr_r;
    reg bus_rd_r;

    wire [3:0] cls;
    wire [6:0] f_addr;
    wire [7:0] f_val;
    wire [7:0] lit;
    wire dst_file;
    wire step;
    wire wake;
    wire bus_take;
    wire [STACK_AW-1:0] sp_top;
    reg [1:0] alu_op;
    reg [7:0] alu_opnd;
    wire [7:0] alu_res;
    wire alu_c;
    wire alu_digit_carry;
    wire alu_z;

    assign cls = insn_class(i_pm_data);
    assign f_addr = i_pm_data[6:0];
    assign f_val = file_mem[f_addr];
    assign lit = i_pm_data[7:0];
    assign dst_file = i_pm_data[`CIE_INSN_DBIT];
    assign sp_top = sp_r - {{(STACK_AW-1){1'b0}}, 1'b1};
    // Second and third stage agree before wake counts
    assign wake = wake_sync_r[1] & wake_sync_r[2];
    assign step = cyc_en_r & ctrl_r[`CIE_CTRL_RUN] & ~sleep_r;
    assign bus_take = i_hsel & i_htrans[1] & i_hready;

    // ----------------------------------------------------------------
    // Datapath
    // ----------------------------------------------------------------
    always @* begin
        alu_op = `CIE_ALU_PASS;
        alu_opnd = f_val;
        case (cls)
            `CIE_CL_ROTATE_LEFT: alu_op = `CIE_ALU_RLC;
            `CIE_CL_ROTATE_RIGHT: alu_op = `CIE_ALU_RRC;
            `CIE_CL_LITERAL_SUB: begin
                alu_op = `CIE_ALU_SUB;
                alu_opnd = lit;
            end
            default: alu_op = `CIE_ALU_PASS;
        endcase
    end

    cie_alu u_alu (
        .i_op(alu_op),
        .i_opnd(alu_opnd),
        .i_wreg(wreg_r),
        .i_carry(status_r[`CIE_ST_C]),
        .o_res(alu_res),
        .o_c(alu_c),
        .o_digit_carry(alu_digit_carry),
        .o_z(alu_z)
    );

    // ----------------------------------------------------------------
    // Instruction cycle divider and wake synchroniser
    // ----------------------------------------------------------------
    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            div_r <= 8'h00;
            cyc_en_r <= 1'b0;
            wake_sync_r <= 3'h0;
        end else begin
            wake_sync_r <= {wake_sync_r[1:0], i_wake};
            if (div_r == CLK_PER_INSN[7:0] - 8'h01) begin
                div_r <= 8'h00;
                cyc_en_r <= 1'b1;
            end else begin
                div_r <= div_r + 8'h01;
                cyc_en_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Watchdog counter and prescaler
    // ----------------------------------------------------------------
    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            wdog_cnt_r <= 8'h00;
            wdog_pre_r <= 8'h00;
        end else if (step && !flush_r && cls == `CIE_CL_SLEEP) begin
            wdog_cnt_r <= 8'h00; // [RL9]
            wdog_pre_r <= 8'h00; // [RL9]
        end else if (cyc_en_r) begin
            // Runs through sleep, as cyc_en_r keeps pulsing while the core halts
            wdog_pre_r <= wdog_pre_r + 8'h01;
            if (wdog_pre_r == 8'hff)
                wdog_cnt_r <= wdog_cnt_r + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // Execution and register bus writes
    // ----------------------------------------------------------------
    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            pc_r <= {PC_W{1'b0}};
            wreg_r <= 8'h00;
            status_r <= `CIE_STATUS_RST;
            ctrl_r <= `CIE_CTRL_RST;
            sleep_r <= 1'b0;
            flush_r <= 1'b0;
            sp_r <= {STACK_AW{1'b0}};
        end else begin
            if (sleep_r && wake)
                sleep_r <= 1'b0;
            if (step) begin
                if (flush_r) begin
                    // Dead second cycle of a return
                    flush_r <= 1'b0; // [RL5] [RL11]
                end else begin
                    pc_r <= pc_r + {{(PC_W-1){1'b0}}, 1'b1}; // [RL14] [RL15]
                    case (cls)
                        `CIE_CL_MOVE_FILE: begin
                            if (dst_file)
                                file_mem[f_addr] <= f_val; // [RL1]
                            else
                                wreg_r <= f_val; // [RL1]
                            status_r[`CIE_ST_Z] <= alu_z; // [RL2]
                        end
                        `CIE_CL_STORE_WORKING: file_mem[f_addr] <= wreg_r; // [RL4]
                        `CIE_CL_LOAD_LITERAL: wreg_r <= lit; // [RL3]
                        `CIE_CL_RETURN_LITERAL: begin
                            wreg_r <= lit; // [RL5]
                            pc_r <= stack_mem[sp_top]; // [RL5]
                            sp_r <= sp_top;
                            flush_r <= 1'b1; // [RL5]
                        end
                        `CIE_CL_IRQ_RETURN: begin
                            pc_r <= stack_mem[sp_top]; // [RL13]
                            sp_r <= sp_top;
                            ctrl_r[`CIE_CTRL_IRQ_EN] <= 1'b1; // [RL13]
                            flush_r <= 1'b1;
                        end
                        `CIE_CL_RETURN: begin
                            pc_r <= stack_mem[sp_top]; // [RL11]
                            sp_r <= sp_top; // [RL11]
                            flush_r <= 1'b1; // [RL11]
                        end
                        `CIE_CL_ROTATE_LEFT, `CIE_CL_ROTATE_RIGHT: begin
                            if (dst_file)
                                file_mem[f_addr] <= alu_res; // [RL6] [RL7]
                            else
                                wreg_r <= alu_res; // [RL6] [RL7]
                            status_r[`CIE_ST_C] <= alu_c; // [RL6] [RL7]
                        end
                        `CIE_CL_SLEEP: begin
                            status_r[`CIE_ST_TIMEOUT] <= 1'b1; // [RL8]
                            status_r[`CIE_ST_POWER_DOWN] <= 1'b0; // [RL8]
                            sleep_r <= 1'b1; // [RL10]
                        end
                        `CIE_CL_LITERAL_SUB: begin
                            wreg_r <= alu_res; // [RL12]
                            status_r[`CIE_ST_C] <= alu_c; // [RL12]
                            status_r[`CIE_ST_DIGIT_CARRY] <= alu_digit_carry; // [RL12]
                            status_r[`CIE_ST_Z] <= alu_z; // [RL12]
                        end
                        default: begin
                            // Idle and unsupported words only advance
                        end
                    endcase
                end
            end
            // Bus write lands last, so it wins over the core
            if (bus_wr_r) begin
                case (bus_addr_r)
                    `CIE_OFS_CTRL: ctrl_r <= i_hwdata[7:0];
                    `CIE_OFS_STATUS: status_r <= i_hwdata[4:0];
                    `CIE_OFS_WREG: wreg_r <= i_hwdata[7:0];
                    `CIE_OFS_PC: begin
                        pc_r <= i_hwdata[PC_W-1:0];
                        flush_r <= 1'b0;
                    end
                    `CIE_OFS_STACK: begin
                        stack_mem[sp_r] <= i_hwdata[PC_W-1:0];
                        sp_r <= sp_r + {{(STACK_AW-1){1'b0}}, 1'b1};
                    end
                    default: begin
                        if (bus_addr_r[11:9] == `CIE_FILE_BASE_HI)
                            file_mem[bus_addr_r[8:2]] <= i_hwdata[7:0];
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // AHB-Lite slave: writes zero wait, reads one wait state
    // ----------------------------------------------------------------
    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            bus_addr_r <= 12'h000;
            bus_wr_r <= 1'b0;
            bus_rd_r <= 1'b0;
            o_hreadyout <= 1'b1;
            o_hrdata <= 32'h00000000;
            o_hresp <= 1'b0;
        end else begin
            o_hresp <= 1'b0;
            bus_wr_r <= 1'b0;
            bus_rd_r <= 1'b0;
            if (bus_rd_r) begin
                // Wait state lets a preceding write settle first
                o_hreadyout <= 1'b1;
                case (bus_addr_r)
                    `CIE_OFS_CTRL: o_hrdata <= {24'h000000, ctrl_r};
                    `CIE_OFS_STATUS: o_hrdata <= {26'h0, sleep_r, status_r};
                    `CIE_OFS_WREG: o_hrdata <= {24'h000000, wreg_r};
                    `CIE_OFS_PC: o_hrdata <= {{(32-PC_W){1'b0}}, pc_r};
                    `CIE_OFS_STACK: o_hrdata <= {{(32-PC_W){1'b0}}, stack_mem[sp_top]};
                    `CIE_OFS_WATCHDOG: o_hrdata <= {16'h0000, wdog_pre_r, wdog_cnt_r};
                    default: begin
                        if (bus_addr_r[11:9] == `CIE_FILE_BASE_HI)
                            o_hrdata <= {24'h000000, file_mem[bus_addr_r[8:2]]};
                        else
                            o_hrdata <= 32'h00000000;
                    end
                endcase
            end else if (bus_take) begin
                bus_addr_r <= {i_haddr[11:2], 2'b00};
                bus_wr_r <= i_hwrite;
                bus_rd_r <= ~i_hwrite;
                o_hreadyout <= i_hwrite;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_pm_addr <= {PC_W{1'b0}};
            o_sleep <= 1'b0;
        end else begin
            o_pm_addr <= pc_r;
            o_sleep <= sleep_r; // [RL10]
        end
    end
endmodule // cie_core

`default_nettype wire

// ### verilog/cie_defs.vh
// What this block does
// RL1 - Move file: d picks working or file
// RL2 - Move file updates zero flag from value
// RL3 - Load literal into working, flags untouched
// RL4 - Store working into file, flags untouched
// RL5 - Literal return: load working, pop, two cycles
// RL6 - Rotate left through carry, destination bit
// RL7 - Rotate right through carry, destination bit
// RL8 - Sleep sets timeout, clears power-down status
// RL9 - Sleep clears watchdog counter and prescaler
// RL10 - Sleep halts core until wake
// RL11 - Subroutine return pops stack, two cycles
// RL12 - Literal minus working, sets carry, digit carry, zero
// RL13 - Interrupt return pops, sets global enable
// RL14 - Idle changes nothing but program counter
// RL15 - Other instructions take one cycle; interrupt return here also takes two cycles (flush_r)
`ifndef CIE_DEFS_VH
`define CIE_DEFS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses, low 12 bits decoded)
// ----------------------------------------------------------------
`define CIE_OFS_CTRL 12'h000
`define CIE_OFS_STATUS 12'h004
`define CIE_OFS_WREG 12'h008
`define CIE_OFS_PC 12'h00c
`define CIE_OFS_STACK 12'h010
`define CIE_OFS_WATCHDOG 12'h014
`define CIE_FILE_BASE_HI 3'h1

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CIE_CTRL_RUN 0
`define CIE_CTRL_IRQ_EN 1
`define CIE_CTRL_RST 8'h00
`define CIE_ST_C 0
`define CIE_ST_DIGIT_CARRY 1
`define CIE_ST_Z 2
`define CIE_ST_POWER_DOWN 3
`define CIE_ST_TIMEOUT 4
`define CIE_ST_SLEEP 5
`define CIE_STATUS_RST 5'h18
`define CIE_INSN_DBIT 7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CIE_CLK_PER_INSN 4

// ----------------------------------------------------------------
// Instruction classes
// ----------------------------------------------------------------
`define CIE_CL_IDLE 4'h0
`define CIE_CL_MOVE_FILE 4'h1
`define CIE_CL_STORE_WORKING 4'h2
`define CIE_CL_LOAD_LITERAL 4'h3
`define CIE_CL_RETURN_LITERAL 4'h4
`define CIE_CL_IRQ_RETURN 4'h5
`define CIE_CL_RETURN 4'h6
`define CIE_CL_ROTATE_LEFT 4'h7
`define CIE_CL_ROTATE_RIGHT 4'h8
`define CIE_CL_SLEEP 4'h9
`define CIE_CL_LITERAL_SUB 4'ha

// ----------------------------------------------------------------
// Datapath operations
// ----------------------------------------------------------------
`define CIE_ALU_PASS 2'h0
`define CIE_ALU_RLC 2'h1
`define CIE_ALU_RRC 2'h2
`define CIE_ALU_SUB 2'h3

`endif
